// ### hdl/hsb_store.sv
// Security byte store, reached only from the parallel programming port.
// Assumes parallel requests are synchronous to sys_clk and one cycle long.
`timescale 1ns/1ps
`default_nettype none

module hsb_store (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Parallel programmer side
  input wire logic par_mode,
  input wire logic par_hsb_wr,
  input wire logic [7:0] par_hsb_wdata,
  input wire logic par_chip_erase,
  // Current security byte
  output flash_ctl_pkg::hsb_s hsb
);

  flash_ctl_pkg::hsb_s hsb_r;
  logic [7:0] wd;

  assign wd = par_hsb_wdata;
  assign hsb = hsb_r;

  // Chip erase restores all ones; safe bit low lets only lock bits fall
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hsb_r <= flash_ctl_pkg::HSB_ERASED;
    end else if (par_mode && par_chip_erase) begin
      hsb_r <= flash_ctl_pkg::HSB_ERASED; // [RULE13]
    end else if (par_mode && par_hsb_wr) begin
      if (hsb_r.safe_lock_bit) begin
        hsb_r <= wd;
      end else begin
        hsb_r.code_lock_level <= hsb_r.code_lock_level & wd[2:0]; // [RULE14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // A guarded byte keeps its upper bits and never loses a lock bit
  chk_safe_guard: assert property ( // [RULE14]
    par_mode && par_hsb_wr && !par_chip_erase && !hsb_r.safe_lock_bit
    |=> hsb_r[7:3] == $past(hsb_r[7:3])
        && (hsb_r[2:0] & ~$past(hsb_r[2:0])) == 3'h0)
    else $error("security byte lowered while safe bit clear");

  // Chip erase leaves all ones
  chk_erase_ones: assert property ( // [RULE13]
    par_mode && par_chip_erase |=> hsb_r == 8'hff)
    else $error("security byte not all ones after erase");

endmodule

`default_nettype wire

// ### hdl/program_flash_control.sv
// Program flash control: control register, column latches, launch key,
// erase-and-program sequencer, space mapping and security decode.
// Assumes the core drives one-cycle SFR, data-move and code-read strobes
// synchronous to sys_clk, and an array macro with combinational read data.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE1] 512 pages of 128 bytes, byte or page
// [RULE2] Each program operation erases its target first
// [RULE3] Erase-and-program takes about 10 ms
// [RULE4] Byte reads with fixed latency, no waits
// [RULE5] Last 1K reserved for loader routines
// [RULE6] Blank boot sector frees full 64K
// [RULE7] Access pin low disables internal program memory
// [RULE8] Launch only after 5h then Ah writes
// [RULE9] Map bit routes data moves to latches
// [RULE10] Space select: user, extra page, security, reserved
// [RULE11] Busy flag hardware owned, software write ignored
// [RULE12] Lower control nibble resets to zero
// [RULE13] Erased security byte reads all ones
// [RULE14] Safe bit clear: security may only rise
// [RULE15] Boot vector select picks 0000h or FC03h
// [RULE16] Loader lock clear blocks software loader writes
// [RULE17] Reserved security bits stay at one; the code writes them from par_hsb_wdata while safe_lock_bit is one
// [RULE18] Security byte only via parallel programming
// [RULE19] Extra page outside normal program space
// [RULE20] Loader segment FC00h-FFFFh, blocked writes do nothing
// [RULE21] Lock level two blocks external table reads
// [RULE22] Other write between keys abandons launch
module program_flash_control #(
  parameter int PROG_CYCLES = flash_ctl_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Data-move writes
  input wire logic xmov_wr,
  input wire logic [15:0] xmov_addr,
  input wire logic [7:0] xmov_wdata,
  output logic map_active,
  // Code-table and fetch reads
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  input wire logic code_from_ext,
  output logic [7:0] code_rdata,
  output logic code_rvalid,
  // Pins and boot status
  input wire logic external_access_pin,
  input wire logic force_loader,
  input wire logic boot_sector_blank,
  output logic [15:0] boot_addr,
  output logic [15:0] app_top,
  output logic int_prog_disable,
  output logic ext_exec_block,
  output logic par_prog_block,
  output logic par_verify_block,
  // Parallel programmer
  input wire logic par_mode,
  input wire logic par_hsb_wr,
  input wire logic [7:0] par_hsb_wdata,
  input wire logic par_chip_erase,
  output logic [7:0] par_hsb_rdata,
  // Flash array macro
  output flash_ctl_pkg::arr_req_s arr_req,
  input wire logic [7:0] arr_rdata
);

  localparam logic [flash_ctl_pkg::TMR_W-1:0] TMR_LAST =
    flash_ctl_pkg::TMR_W'((PROG_CYCLES > 1) ? PROG_CYCLES - 1 : 0);
  localparam int NB = flash_ctl_pkg::PAGE_BYTES;
  localparam int IW = flash_ctl_pkg::PAGE_IDX_W;
  localparam int PW = flash_ctl_pkg::PAGE_NUM_W;
  localparam logic [IW-1:0] IDX_LAST = IW'(NB - 1);

  flash_ctl_pkg::hsb_s hsb;
  flash_ctl_pkg::prog_state_e state_r;
  flash_ctl_pkg::arr_req_s arr_req_r;
  logic [3:0] key_nib_r;
  logic map_r;
  logic [1:0] space_r;
  logic busy_r;
  logic armed_r;
  logic [7:0] lat_data_r [NB];
  logic [NB-1:0] lat_ok_r;
  logic [IW:0] lat_cnt_r;
  logic [PW-1:0] lat_page_r;
  logic [1:0] lat_space_r;
  logic [IW-1:0] first_idx_r;
  logic [flash_ctl_pkg::TMR_W-1:0] tmr_r;
  logic [IW-1:0] idx_r;
  logic rd_pend_r;
  logic rd_blk_r;
  logic rd_blk2_r;
  logic rd_pend2_r;
  logic [7:0] sfr_rdata_r;
  logic [7:0] code_rdata_r;
  logic code_rvalid_r;
  logic [15:0] boot_addr_r;
  logic [15:0] app_top_r;
  logic int_dis_r;
  logic ext_blk_r;
  logic par_prog_blk_r;
  logic par_ver_blk_r;
  logic [7:0] par_hsb_rdata_r;
  logic ea_latched_r;
  logic ea_seen_r;
  logic flash_control_wr;
  logic key2_wr;
  logic boot_hit;
  logic launch_ok;
  logic lat_wr;
  logic lvl_ge2;
  logic lvl_ge3;
  logic lvl_ge4;
  logic ea_eff;
  logic [IW-1:0] xidx;

  ////////////////////////////////////////////////////////////////////////////
  // Security byte store
  hsb_store u_hsb (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .par_mode(par_mode),
    .par_hsb_wr(par_hsb_wr),
    .par_hsb_wdata(par_hsb_wdata),
    .par_chip_erase(par_chip_erase),
    .hsb(hsb)
  );

  // Lock level decode, lock bits active low
  assign lvl_ge2 = ~&hsb.code_lock_level;
  assign lvl_ge3 = ~&hsb.code_lock_level[2:1];
  assign lvl_ge4 = ~hsb.code_lock_level[2];
  assign ea_eff = lvl_ge2 ? ea_latched_r : external_access_pin;

  // Request decode
  assign flash_control_wr = sfr_wr && (sfr_addr == flash_ctl_pkg::FLASH_CONTROL_ADDR);
  assign key2_wr = flash_control_wr && armed_r
    && (sfr_wdata[flash_ctl_pkg::KEY_HI:flash_ctl_pkg::KEY_LO]
        == flash_ctl_pkg::KEY_SECOND);
  assign boot_hit = (lat_space_r == flash_ctl_pkg::SPACE_USER)
    && (lat_page_r >= flash_ctl_pkg::LOADER_BASE[15:IW]);
  assign launch_ok = key2_wr && (state_r == flash_ctl_pkg::ST_IDLE)
    && (lat_cnt_r != '0)
    && !(boot_hit && !hsb.loader_lock) // [RULE16] [RULE20]
    && !lat_space_r[1]; // [RULE18]
  assign xidx = xmov_addr[IW-1:0];
  assign lat_wr = xmov_wr && map_r // [RULE9]
    && (state_r == flash_ctl_pkg::ST_IDLE) && !space_r[1]
    && ((lat_cnt_r == '0) || (xmov_addr[15:IW] == lat_page_r));

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields; busy bit is not writable
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_nib_r <= flash_ctl_pkg::KEY_RST;
      map_r <= flash_ctl_pkg::MAP_RST; // [RULE12]
      space_r <= flash_ctl_pkg::SPACE_RST; // [RULE12]
    end else if (flash_control_wr) begin
      key_nib_r <= sfr_wdata[flash_ctl_pkg::KEY_HI:flash_ctl_pkg::KEY_LO];
      map_r <= sfr_wdata[flash_ctl_pkg::MAP_BIT];
      space_r <= sfr_wdata[flash_ctl_pkg::SPACE_HI:flash_ctl_pkg::SPACE_LO];
    end
  end

  // Launch key: first nibble arms, anything else disarms
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b0;
    end else if (flash_control_wr) begin
      armed_r <= (sfr_wdata[flash_ctl_pkg::KEY_HI:flash_ctl_pkg::KEY_LO]
                  == flash_ctl_pkg::KEY_FIRST); // [RULE8] [RULE22]
    end
  end

  // Busy flag owned by hardware
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0; // [RULE12]
    end else if (launch_ok) begin
      busy_r <= 1'b1; // [RULE11]
    end else if (state_r == flash_ctl_pkg::ST_DONE) begin
      busy_r <= 1'b0; // [RULE11]
    end
  end

  // Register read answer, zero for other addresses
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd
        && (sfr_addr == flash_ctl_pkg::FLASH_CONTROL_ADDR)) begin
      sfr_rdata_r <= {key_nib_r, map_r, space_r, busy_r};
    end else begin
      sfr_rdata_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column latches: page and space fixed by the first write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_page_r <= '0;
      lat_space_r <= flash_ctl_pkg::SPACE_USER;
      first_idx_r <= '0;
    end else if (lat_wr && (lat_cnt_r == '0)) begin
      lat_page_r <= xmov_addr[15:IW]; // [RULE1]
      lat_space_r <= space_r; // [RULE10]
      first_idx_r <= xidx;
    end
  end

  // Count of loaded entries picks byte or page mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_cnt_r <= '0;
    end else if (state_r == flash_ctl_pkg::ST_DONE) begin
      lat_cnt_r <= '0;
    end else if (lat_wr && !lat_ok_r[xidx]) begin
      lat_cnt_r <= lat_cnt_r + 1'b1;
    end
  end

  // One data byte and a loaded flag per latch entry
  for (genvar i = 0; i < NB; i++) begin : g_lat
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        lat_data_r[i] <= flash_ctl_pkg::BLANK_BYTE;
        lat_ok_r[i] <= 1'b0;
      end else if (state_r == flash_ctl_pkg::ST_DONE) begin
        lat_ok_r[i] <= 1'b0;
      end else if (lat_wr && (xidx == IW'(i))) begin
        lat_data_r[i] <= xmov_wdata;
        lat_ok_r[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: erase, wait the program time, write loaded bytes, finish
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= flash_ctl_pkg::ST_IDLE;
    end else begin
      case (state_r)
        flash_ctl_pkg::ST_IDLE: begin
          if (launch_ok) begin
            state_r <= flash_ctl_pkg::ST_ERASE;
          end
        end
        flash_ctl_pkg::ST_ERASE: begin
          state_r <= flash_ctl_pkg::ST_WAIT;
        end
        flash_ctl_pkg::ST_WAIT: begin
          if (tmr_r == TMR_LAST) begin
            state_r <= flash_ctl_pkg::ST_WRITE; // [RULE3]
          end
        end
        flash_ctl_pkg::ST_WRITE: begin
          if (idx_r == IDX_LAST) begin
            state_r <= flash_ctl_pkg::ST_DONE;
          end
        end
        flash_ctl_pkg::ST_DONE: begin
          state_r <= flash_ctl_pkg::ST_IDLE;
        end
        default: begin
          state_r <= flash_ctl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Program timer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_r <= '0;
    end else if (state_r == flash_ctl_pkg::ST_WAIT) begin
      tmr_r <= tmr_r + 1'b1; // [RULE3]
    end else begin
      tmr_r <= '0;
    end
  end

  // Latch entry walk during the write phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_r <= '0;
    end else if (state_r == flash_ctl_pkg::ST_WRITE) begin
      idx_r <= idx_r + 1'b1;
    end else begin
      idx_r <= '0;
    end
  end

  // Array requests: programming owns the array, reads otherwise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arr_req_r <= flash_ctl_pkg::ARR_IDLE;
    end else begin
      arr_req_r <= flash_ctl_pkg::ARR_IDLE;
      arr_req_r.byte_mode <= (lat_cnt_r == (IW+1)'(1));
      arr_req_r.space <= lat_space_r; // [RULE19]
      if (state_r == flash_ctl_pkg::ST_ERASE) begin
        arr_req_r.erase <= 1'b1; // [RULE2]
        arr_req_r.addr <= {lat_page_r, first_idx_r};
      end else if (state_r == flash_ctl_pkg::ST_WRITE) begin
        arr_req_r.write <= lat_ok_r[idx_r];
        arr_req_r.addr <= {lat_page_r, idx_r};
        arr_req_r.data <= lat_data_r[idx_r];
      end else if (code_rd && !busy_r) begin
        arr_req_r.read <= 1'b1;
        arr_req_r.space <= map_r ? space_r : flash_ctl_pkg::SPACE_USER;
        arr_req_r.addr <= (map_r && (space_r == flash_ctl_pkg::SPACE_XAF))
          ? {9'h000, code_addr[IW-1:0]} : code_addr; // [RULE19]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: two-cycle fixed latency, blocked reads return all ones
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_r <= 1'b0;
      rd_blk_r <= 1'b0;
    end else begin
      rd_pend_r <= code_rd; // [RULE4]
      rd_blk_r <= busy_r || !ea_eff // [RULE7]
        || (code_from_ext && lvl_ge2) // [RULE21]
        || (map_r && space_r[1]); // [RULE18] [RULE10]
    end
  end

  // Data capture stage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_rdata_r <= 8'h00;
      code_rvalid_r <= 1'b0;
    end else begin
      code_rvalid_r <= rd_pend_r; // [RULE4]
      if (rd_pend_r) begin
        code_rdata_r <= rd_blk_r ? flash_ctl_pkg::BLANK_BYTE : arr_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access pin caught once after reset release, held at lock level two
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ea_seen_r <= 1'b0;
      ea_latched_r <= 1'b1;
    end else if (!ea_seen_r) begin
      ea_seen_r <= 1'b1;
      ea_latched_r <= external_access_pin;
    end
  end

  // Boot vector, application limit and protection outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_addr_r <= flash_ctl_pkg::BOOT_VEC_LOADER;
      app_top_r <= flash_ctl_pkg::APP_TOP_ISP;
      int_dis_r <= 1'b0;
      ext_blk_r <= 1'b0;
      par_prog_blk_r <= 1'b0;
      par_ver_blk_r <= 1'b0;
    end else begin
      boot_addr_r <= (hsb.boot_vector_select && !force_loader)
        ? flash_ctl_pkg::BOOT_VEC_APP
        : flash_ctl_pkg::BOOT_VEC_LOADER; // [RULE15]
      app_top_r <= boot_sector_blank ? flash_ctl_pkg::APP_TOP_FULL // [RULE6]
        : flash_ctl_pkg::APP_TOP_ISP; // [RULE5]
      int_dis_r <= !ea_eff; // [RULE7]
      ext_blk_r <= lvl_ge4; // [RULE21]
      par_prog_blk_r <= lvl_ge2; // [RULE21]
      par_ver_blk_r <= lvl_ge3; // [RULE21]
    end
  end

  // Security byte readback, only in parallel mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_hsb_rdata_r <= flash_ctl_pkg::HSB_ERASED;
    end else if (par_mode) begin
      par_hsb_rdata_r <= hsb; // [RULE18]
    end
  end

  // Output drive
  assign sfr_rdata = sfr_rdata_r;
  assign map_active = map_r;
  assign code_rdata = code_rdata_r;
  assign code_rvalid = code_rvalid_r;
  assign boot_addr = boot_addr_r;
  assign app_top = app_top_r;
  assign int_prog_disable = int_dis_r;
  assign ext_exec_block = ext_blk_r;
  assign par_prog_block = par_prog_blk_r;
  assign par_verify_block = par_ver_blk_r;
  assign par_hsb_rdata = par_hsb_rdata_r;
  assign arr_req = arr_req_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_busy_launch: assert property ( // [RULE11]
    launch_ok |=> busy_r && state_r == flash_ctl_pkg::ST_ERASE)
    else $error("launch did not raise busy");

  chk_key_order: assert property ( // [RULE8]
    $rose(busy_r) |-> $past(armed_r) && $past(flash_control_wr))
    else $error("busy rose without the key pair");

  chk_key_abandon: assert property ( // [RULE22]
    flash_control_wr && sfr_wdata[7:4] != 4'h5 |=> !armed_r ##1 !$rose(busy_r))
    else $error("launch key not abandoned");

  chk_erase_first: assert property ( // [RULE2]
    state_r == flash_ctl_pkg::ST_ERASE |=> arr_req_r.erase && !arr_req_r.write)
    else $error("no erase at start of programming");

  chk_prog_time: assert property ( // [RULE3]
    state_r == flash_ctl_pkg::ST_WRITE
    && $past(state_r) == flash_ctl_pkg::ST_WAIT |-> $past(tmr_r) == TMR_LAST)
    else $error("program wait length wrong");

  chk_read_delay: assert property ( // [RULE4]
    code_rd |-> ##2 code_rvalid_r)
    else $error("read answer not two cycles later");

  chk_lock_read: assert property ( // [RULE21]
    code_rd && code_from_ext && lvl_ge2 |-> ##2 code_rdata_r == 8'hff)
    else $error("locked external table read leaked data");

  chk_loader_guard: assert property ( // [RULE20]
    key2_wr && boot_hit && !hsb.loader_lock && !busy_r |=> !busy_r)
    else $error("write into locked loader segment launched");

  chk_boot_vector: assert property ( // [RULE15]
    hsb.boot_vector_select && !force_loader |=> boot_addr_r == 16'h0000)
    else $error("boot vector not 0000h");

endmodule

`default_nettype wire

// ### pkg/flash_ctl_pkg.sv
// Constants, field layouts and types of the program flash control block.
// Assumes a core clock of 250 MHz; shared by the control and security files.
package flash_ctl_pkg;

  // Register placement in the core's special function register space
  localparam logic [7:0] FLASH_CONTROL_ADDR = 8'hd1;

  // Array organisation
  localparam int PAGE_COUNT = 512;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_IDX_W = 7;
  localparam int PAGE_NUM_W = 9;

  // Launch key nibbles
  localparam logic [3:0] KEY_FIRST = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'ha;
  localparam logic [3:0] KEY_RST = 4'h0;

  // Control register field positions and reset values
  localparam int KEY_HI = 7;
  localparam int KEY_LO = 4;
  localparam int MAP_BIT = 3;
  localparam int SPACE_HI = 2;
  localparam int SPACE_LO = 1;
  localparam int BUSY_BIT = 0;
  localparam logic MAP_RST = 1'b0;
  localparam logic [1:0] SPACE_RST = 2'h0;

  // Space select codes
  localparam logic [1:0] SPACE_USER = 2'h0;
  localparam logic [1:0] SPACE_XAF = 2'h1;
  localparam logic [1:0] SPACE_HSB = 2'h2;
  localparam logic [1:0] SPACE_RSVD = 2'h3;

  // Security byte and address map values
  localparam logic [7:0] HSB_ERASED = 8'hff;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [15:0] LOADER_BASE = 16'hfc00;
  localparam logic [15:0] BOOT_VEC_LOADER = 16'hfc03;
  localparam logic [15:0] BOOT_VEC_APP = 16'h0000;
  localparam logic [15:0] APP_TOP_FULL = 16'hffff;
  localparam logic [15:0] APP_TOP_ISP = 16'hfbff;

  // Erase-and-program time and its cycle count at the core clock
  localparam int PROG_TIME_MS = 10;
  localparam int CLK_KHZ = 250000;
  localparam int PROG_CYCLES = PROG_TIME_MS * CLK_KHZ;
  localparam int TMR_W = 22;

  // Security byte layout, every bit active low
  typedef struct packed {
    logic safe_lock_bit;
    logic boot_vector_select;
    logic loader_lock;
    logic [1:0] rsvd;
    logic [2:0] code_lock_level;
  } hsb_s;

  // One request to the flash array macro
  typedef struct packed {
    logic read;
    logic erase;
    logic write;
    logic byte_mode;
    logic [1:0] space;
    logic [15:0] addr;
    logic [7:0] data;
  } arr_req_s;

  localparam arr_req_s ARR_IDLE = '0;

  // Programming sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ERASE = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_DONE = 5'b10000
  } prog_state_e;

endpackage

// ### tb/core_model.sv
// Core stand-in: register strobes, data-move writes and code reads.
// Assumes sys_clk from the bench; tasks act just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Data moves and code reads
  output logic xmov_wr,
  output logic [15:0] xmov_addr,
  output logic [7:0] xmov_wdata,
  output logic code_rd,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_rdata,
  input wire logic code_rvalid
);
  // Idle at time zero
  initial begin
    {sfr_wr, sfr_rd, xmov_wr, code_rd} = 4'h0;
    {sfr_addr, sfr_wdata, xmov_addr, xmov_wdata, code_addr} = '0;
  end
  // Register write; key pairs come from the caller
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge sys_clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr} = {~a, ~d, 1'b0};
  endtask
  // Register read, data one cycle after the strobe
  task automatic sfr_r(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge sys_clk);
    #1 {sfr_addr, sfr_rd} = {~a, 1'b0};
    d = sfr_rdata;
  endtask
  // Data-move write toward the column latches
  task automatic xmov(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {xmov_addr, xmov_wdata, xmov_wr} = {a, d, 1'b1};
    @(posedge sys_clk);
    #1 {xmov_addr, xmov_wdata, xmov_wr} = {~a, ~d, 1'b0};
  endtask
  // Code read; counts edges until valid, bounded
  task automatic code_r(input logic [15:0] a, output logic [7:0] d,
                        output int lat);
    @(posedge sys_clk);
    #1 {code_addr, code_rd} = {a, 1'b1};
    @(posedge sys_clk);
    #1 {code_addr, code_rd} = {~a, 1'b0};
    lat = 1;
    while (code_rvalid !== 1'b1 && lat < 8) begin
      @(posedge sys_clk);
      #1 lat = lat + 1;
    end
    d = code_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/program_flash_control_bench.sv
// Self-checking bench for the program flash control block.
// Assumes core_model as partner and a combinational array stand-in.
`timescale 1ns/1ps
`default_nettype none
module program_flash_control_bench;
  logic sys_clk, rst_b, sfr_wr, sfr_rd, xmov_wr, code_rd, code_rvalid;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xmov_wdata, code_rdata;
  logic [15:0] xmov_addr, code_addr, boot_addr, app_top, a;
  logic map_active, int_prog_disable, ext_exec_block, par_prog_block;
  logic par_verify_block, ext_pin, par_mode, par_hsb_wr, par_chip_erase;
  logic [7:0] par_hsb_wdata, par_hsb_rdata, arr_rdata, d, wd, hsb_m;
  logic fx, fl, bb;
  flash_ctl_pkg::arr_req_s arr_req;
  int failures, samples_checked, cyc, erases, t_er, t_wr, n, lat;
  logic [23:0] wq[$];
  ////////////////////////////////////////////////////////////////////////
  // Clock and array stand-in
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  assign arr_rdata = arr_req.addr[7:0] ^ 8'h5a;
  program_flash_control #(.PROG_CYCLES(20)) program_flash_control_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xmov_wr(xmov_wr), .xmov_addr(xmov_addr),
    .xmov_wdata(xmov_wdata), .map_active(map_active),
    .code_rd(code_rd), .code_addr(code_addr), .code_from_ext(fx),
    .code_rdata(code_rdata), .code_rvalid(code_rvalid),
    .external_access_pin(ext_pin), .force_loader(fl),
    .boot_sector_blank(bb), .boot_addr(boot_addr), .app_top(app_top),
    .int_prog_disable(int_prog_disable), .ext_exec_block(ext_exec_block),
    .par_prog_block(par_prog_block), .par_verify_block(par_verify_block),
    .par_mode(par_mode), .par_hsb_wr(par_hsb_wr),
    .par_hsb_wdata(par_hsb_wdata), .par_chip_erase(par_chip_erase),
    .par_hsb_rdata(par_hsb_rdata), .arr_req(arr_req),
    .arr_rdata(arr_rdata));
  core_model core_model_inst (
    .sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .xmov_wr(xmov_wr), .xmov_addr(xmov_addr), .xmov_wdata(xmov_wdata),
    .code_rd(code_rd), .code_addr(code_addr), .code_rdata(code_rdata),
    .code_rvalid(code_rvalid));
  ////////////////////////////////////////////////////////////////////////
  // Array pulse log and run limit
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (arr_req.erase === 1'b1) begin
      erases++;
      t_er = cyc;
    end
    if (arr_req.write === 1'b1) begin
      wq.push_back({arr_req.addr, arr_req.data});
      t_wr = cyc;
    end
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Security byte write or erase, reserved bits one
  task automatic par(input logic [7:0] v, input logic er);
    hsb_m = er ? 8'hff : hsb_m[7] ? v : {hsb_m[7:3], hsb_m[2:0] & v[2:0]};
    @(posedge sys_clk);
    #1 {par_hsb_wdata, par_hsb_wr, par_chip_erase} = {v, ~er, er};
    @(posedge sys_clk);
    #1 {par_hsb_wdata, par_hsb_wr, par_chip_erase} = {~v, 2'b00};
    @(posedge sys_clk);
    #1 chk(par_hsb_rdata, hsb_m);
  endtask
  // Key pair, maybe broken; busy counted by reads
  task automatic launch(input bit abandon, output int busy_n);
    logic [7:0] r;
    core_model_inst.sfr_w(8'hd1, 8'h58);
    if (abandon) core_model_inst.sfr_w(8'hd1, 8'h38);
    core_model_inst.sfr_w(8'hd1, 8'ha8);
    busy_n = 0;
    repeat (150) begin
      core_model_inst.sfr_r(8'hd1, r);
      if (r[0] === 1'b1) busy_n++;
    end
    chk(r, 8'ha8);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {failures, samples_checked, cyc, erases, t_er, t_wr} = '0;
    {rst_b, par_mode, par_hsb_wr, par_chip_erase, fx, fl, bb} = 7'h00;
    {ext_pin, par_hsb_wdata, hsb_m} = {1'b1, 8'h00, 8'hff};
    void'($urandom(78071));
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    core_model_inst.sfr_r(8'hd1, d);
    chk(d, 8'h00);
    chk(boot_addr, 16'h0000);
    {fl, bb} = 2'h3;
    core_model_inst.sfr_w(8'hd1, 8'h09);
    core_model_inst.sfr_w(8'hd2, 8'h00);
    core_model_inst.sfr_r(8'hd1, d);
    chk(d, 8'h08);
    chk(map_active, 1'b1);
    chk({boot_addr, app_top[15:8]}, 24'hfc03ff);
    $display("test register done");
    {par_mode, fl, bb} = 3'h4;
    par(8'h9f, 1'b0);
    chk({boot_addr, app_top[15:8]}, 24'hfc03fb);
    a = {9'h1f8 + 9'($urandom_range(0, 7)), 7'($urandom_range(0, 127))};
    wd = 8'($urandom);
    core_model_inst.xmov(a, wd);
    launch(1'b0, n);
    chk({8'(n), 8'(erases)}, 0);
    par(8'hff, 1'b0);
    launch(1'b0, n);
    chk({n > 0, 8'(erases), 8'(wq.size())}, 17'h10101);
    chk(wq.pop_front(), {a, wd});
    chk(t_wr - t_er - int'(a[6:0]) >= 20, 1'b1);
    $display("test program done");
    a = {9'($urandom_range(0, 503)), 7'($urandom_range(0, 127))};
    core_model_inst.xmov(a, wd);
    launch(1'b1, n);
    chk({8'(n), 8'(erases)}, 1);
    launch(1'b0, n);
    chk(wq.pop_front(), {a, wd});
    $display("test abandoned key done");
    core_model_inst.sfr_w(8'hd1, 8'h0a);
    core_model_inst.code_r(a, d, lat);
    core_model_inst.sfr_w(8'hd1, 8'h0c);
    core_model_inst.code_r(a, wd, lat);
    chk({d, wd}, {1'b0, a[6:0] ^ 7'h5a, 8'hff});
    core_model_inst.sfr_w(8'hd1, 8'h00);
    repeat (4) begin
      a = 16'($urandom_range(0, 16'hfbff));
      core_model_inst.code_r(a, d, lat);
      chk({d, lat <= 2}, {a[7:0] ^ 8'h5a, 1'b1});
    end
    ext_pin = 1'b0;
    core_model_inst.code_r(a, d, lat);
    chk({d, int_prog_disable}, {8'hff, 1'b1});
    ext_pin = 1'b1;
    $display("test code reads done");
    par(8'h1f, 1'b0);
    par(8'hff, 1'b0);
    par(8'h1d, 1'b0);
    chk({par_prog_block, par_verify_block}, 2'b11);
    fx = 1'b1;
    core_model_inst.code_r(a, d, lat);
    chk({d, ext_exec_block}, 9'h1fe);
    par(8'h00, 1'b1);
    $display("test security byte done");
    end_sim();
  end
endmodule
`default_nettype wire
